/* pss_serial_port_select.sv */
// Notes on behaviour
// RQ1: The link runs at 19200 baud, eight data bits, no parity and one stop bit both ways.
// RQ2: No flow control of any kind is used; bytes go out without handshake pins.
// RQ3: Every byte that is a valid command is echoed unchanged to the sender.
// RQ4: Each received byte is a whole command and alone decides the routed channel.
// RQ5: Bytes 10h to 1Fh pick channels 1 to 16, and 71h deselects all and blanks video.
// RQ6: Every change of selected channel sends that channel's command on the auxiliary output; here changes made during a send collapse to the latest channel.
// RQ7: A byte equal to a leader's channel-change command switches this unit to that channel.
// RQ8: A follower's transmit line must never be wired back to the leader's receive input.
// RQ9: A byte outside the command set changes nothing and is not echoed.
`timescale 1ns/1ns
`include "pss_defs.svh"
module pss_serial_port_select (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic rxd_i,
	input wire logic chan_set_i,
	input wire logic [4:0] chan_set_val_i,
	output logic txd_o,
	output logic aux_txd_o,
	output logic [4:0] chan_o,
	output logic video_on_o,
	output logic frame_err_o
);
	function automatic logic pss_is_cmd(input logic [7:0] b);
		logic in_range;
		logic is_off;
		in_range = (b >= `PSS_CMD_FIRST) && (b <= `PSS_CMD_LAST);
		is_off = (b == `PSS_CMD_OFF);
		return in_range || is_off;
	endfunction
	function automatic logic [4:0] pss_cmd_to_chan(input logic [7:0] b);
		logic [4:0] c;
		if (b == `PSS_CMD_OFF) begin
			c = `PSS_CHAN_OFF;
		end else begin
			// Low nibble counts channels from zero
			c = {1'b0, b[3:0]} + 5'h01;
		end
		return c;
	endfunction
	function automatic logic [7:0] pss_chan_to_cmd(input logic [4:0] c);
		logic [7:0] b;
		if (c == `PSS_CHAN_OFF) begin
			b = `PSS_CMD_OFF;
		end else begin
			// Channel 16 wraps the nibble to 0xf
			b = `PSS_CMD_FIRST + {4'h0, c[3:0] - 4'h1};
		end
		return b;
	endfunction

	// Receiver, sampling at mid bit; rxd is taken as synchronous
	pss_pkg::pss_rx_state_t rx_state_q;
	logic [15:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_done_q;
	logic [7:0] rx_byte_q;
	logic stop_at;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_state_q <= pss_pkg::RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
		end else begin
			case (rx_state_q)
				pss_pkg::RX_IDLE: begin
					rx_cnt_q <= 16'h0000;
					if (!rxd_i) begin
						rx_state_q <= pss_pkg::RX_START;
					end
				end
				pss_pkg::RX_START: begin
					if (rx_cnt_q == 16'(`PSS_HALF_CYC - 1)) begin
						rx_cnt_q <= 16'h0000;
						rx_bit_q <= 3'h0;
						// Glitch shorter than half a bit is dropped
						rx_state_q <= rxd_i ? pss_pkg::RX_IDLE : pss_pkg::RX_DATA;
					end else begin
						rx_cnt_q <= rx_cnt_q + 16'h0001;
					end
				end
				pss_pkg::RX_DATA: begin
					if (rx_cnt_q == 16'(`PSS_BIT_CYC - 1)) begin
						rx_cnt_q <= 16'h0000;
						rx_sh_q <= {rxd_i, rx_sh_q[7:1]}; // RQ1
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'(`PSS_DATA_BITS - 1)) begin
							rx_state_q <= pss_pkg::RX_STOP;
						end
					end else begin
						rx_cnt_q <= rx_cnt_q + 16'h0001;
					end
				end
				pss_pkg::RX_STOP: begin
					if (rx_cnt_q == 16'(`PSS_BIT_CYC - 1)) begin
						rx_state_q <= pss_pkg::RX_IDLE;
					end else begin
						rx_cnt_q <= rx_cnt_q + 16'h0001;
					end
				end
				default: rx_state_q <= pss_pkg::RX_IDLE;
			endcase
		end
	end

	// Stop bit verdict; no parity bit, a missing stop bit discards the byte
	always_comb begin
		stop_at = (rx_state_q == pss_pkg::RX_STOP) && (rx_cnt_q == 16'(`PSS_BIT_CYC - 1));
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_done_q <= 1'b0;
			rx_byte_q <= 8'h00;
			frame_err_o <= 1'b0;
		end else begin
			rx_done_q <= stop_at && rxd_i; // RQ1
			frame_err_o <= stop_at && !rxd_i;
			if (stop_at && rxd_i) begin
				rx_byte_q <= rx_sh_q;
			end
		end
	end

	// Channel selection; serial command wins over a local request in the same cycle
	logic [4:0] chan_q;
	logic video_q;
	logic chg_pend_q;
	logic echo_pend_q;
	logic [7:0] echo_byte_q;
	logic rx_valid;
	logic local_ok;
	logic [4:0] new_chan;
	logic do_set;
	logic chan_chg;
	always_comb begin
		rx_valid = rx_done_q && pss_is_cmd(rx_byte_q); // RQ4 RQ9
		local_ok = chan_set_i && (chan_set_val_i <= `PSS_CHAN_MAX);
		if (rx_valid) begin
			new_chan = pss_cmd_to_chan(rx_byte_q); // RQ5
		end else begin
			new_chan = chan_set_val_i;
		end
		do_set = rx_valid || local_ok;
		chan_chg = do_set && (new_chan != chan_q);
	end
	// Video flag kept as its own flop so the output needs no decode
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			chan_q <= `PSS_CHAN_OFF;
			video_q <= 1'b0;
		end else if (do_set) begin
			chan_q <= new_chan; // RQ7
			video_q <= (new_chan != `PSS_CHAN_OFF); // RQ5
		end
	end
	assign chan_o = chan_q;
	assign video_on_o = video_q;

	// Pending flags: a new event wins over the clear of the old one
	pss_tx_if echo_if ();
	pss_tx_if aux_if ();
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			echo_pend_q <= 1'b0;
			echo_byte_q <= 8'h00;
		end else if (rx_valid) begin
			echo_pend_q <= 1'b1; // RQ3
			echo_byte_q <= rx_byte_q;
		end else if (echo_if.ready) begin
			echo_pend_q <= 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			chg_pend_q <= 1'b0;
		end else if (chan_chg) begin
			chg_pend_q <= 1'b1; // RQ6
		end else if (aux_if.ready) begin
			chg_pend_q <= 1'b0;
		end
	end
	// Only the latest channel is sent; changes made during a send collapse to one byte
	assign echo_if.valid = echo_pend_q;
	assign echo_if.data = echo_byte_q;
	assign aux_if.valid = chg_pend_q;
	assign aux_if.data = pss_chan_to_cmd(chan_q); // RQ6

	// Two free-running transmitters, no handshake lines exist
	pss_uart_tx u_echo_tx ( // RQ2
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.req(echo_if),
		.txd_o(txd_o)
	);
	pss_uart_tx u_aux_tx (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.req(aux_if),
		.txd_o(aux_txd_o)
	);
endmodule

/* pss_defs.svh */
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_CLK_HZ 100000000
`define PSS_BAUD 19200
`define PSS_BIT_CYC (`PSS_CLK_HZ / `PSS_BAUD)
`define PSS_HALF_CYC (`PSS_BIT_CYC / 2)
`define PSS_DATA_BITS 8
`define PSS_CMD_FIRST 8'h10
`define PSS_CMD_LAST 8'h1f
`define PSS_CMD_OFF 8'h71
`define PSS_CHAN_OFF 5'h00
`define PSS_CHAN_MAX 5'h10
`endif

/* pss_pkg.sv */
package pss_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} pss_rx_state_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} pss_tx_state_t;
endpackage

/* pss_tx_if.sv */
`timescale 1ns/1ns
interface pss_tx_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* pss_uart_tx.sv */
`timescale 1ns/1ns
`include "pss_defs.svh"
module pss_uart_tx (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	pss_tx_if.snk req,
	output logic txd_o
);
	pss_pkg::pss_tx_state_t state_q;
	logic [15:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	assign req.ready = (state_q == pss_pkg::TX_IDLE);
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_q <= pss_pkg::TX_IDLE;
			cnt_q <= 16'h0000;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			txd_o <= 1'b1;
		end else begin
			case (state_q)
				pss_pkg::TX_IDLE: begin
					txd_o <= 1'b1;
					if (req.valid) begin
						sh_q <= req.data;
						txd_o <= 1'b0;
						cnt_q <= 16'h0000;
						state_q <= pss_pkg::TX_START;
					end
				end
				pss_pkg::TX_START, pss_pkg::TX_DATA: begin
					if (cnt_q == 16'(`PSS_BIT_CYC - 1)) begin
						cnt_q <= 16'h0000;
						if (state_q == pss_pkg::TX_START) begin
							bit_q <= 3'h0;
							state_q <= pss_pkg::TX_DATA;
							txd_o <= sh_q[0];
						end else if (bit_q == 3'h7) begin
							state_q <= pss_pkg::TX_STOP;
							txd_o <= 1'b1;
						end else begin
							bit_q <= bit_q + 3'h1;
							txd_o <= sh_q[bit_q + 3'h1];
						end
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				pss_pkg::TX_STOP: begin
					if (cnt_q == 16'(`PSS_BIT_CYC - 1)) begin
						state_q <= pss_pkg::TX_IDLE;
						cnt_q <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				default: state_q <= pss_pkg::TX_IDLE;
			endcase
		end
	end
endmodule

/* pss_props.sv */
`timescale 1ns/1ns
module pss_props (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic rxd_i,
	input wire logic chan_set_i,
	input wire logic [4:0] chan_set_val_i,
	input wire logic txd_o,
	input wire logic aux_txd_o,
	input wire logic [4:0] chan_o,
	input wire logic video_on_o,
	input wire logic frame_err_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Outputs idle only once a whole frame has passed since the last change
	logic [16:0] gap_q;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) gap_q <= 17'h1ffff;
		else if ($changed(chan_o)) gap_q <= 17'h0;
		else if (gap_q != 17'h1ffff) gap_q <= gap_q + 17'h1;
	end
	a_video_follows: assert property (video_on_o == (chan_o != 5'h0)) else $error("video");
	a_chan_range: assert property (chan_o <= 5'h10) else $error("range");
	a_local_take: assert property (chan_set_i && chan_set_val_i <= 5'h10 |=>
		chan_o == $past(chan_set_val_i)) else $error("local");
	a_aux_change: assert property ($changed(chan_o) && gap_q > 17'd52100 |=>
		$fell(aux_txd_o)) else $error("aux");
	a_serial_moment: assert property ($changed(chan_o) && !$past(chan_set_i) |->
		$past(rxd_i)) else $error("moment");
	a_echo_start: assert property ($changed(chan_o) && !$past(chan_set_i) &&
		gap_q > 17'd52100 |=> $fell(txd_o)) else $error("echo");
	a_frame_err: assert property (frame_err_o |-> !$past(rxd_i)) else $error("ferr");
	a_reset_idle: assert property ($past(sys_rst_i) |-> txd_o && aux_txd_o &&
		chan_o == 5'h0 && !frame_err_o) else $error("reset");
	c_serial: cover property ($changed(chan_o) && !$past(chan_set_i));
	c_local: cover property (chan_set_i);
	c_off: cover property ($fell(video_on_o));
endmodule

/* pss_host.sv */
`timescale 1ns/1ns
`include "pss_defs.svh"
module pss_host (
	input wire logic clk_i,
	input wire logic txd_i,
	output logic rxd_o
);
	initial rxd_o = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat (`PSS_BIT_CYC) @(posedge clk_i);
		end
	endtask
	// Listen only, never fed back to the line we drive
	task automatic recv(output logic [7:0] b);
		@(negedge txd_i);
		repeat (`PSS_HALF_CYC) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (`PSS_BIT_CYC) @(posedge clk_i);
			b[i] = txd_i;
		end
	endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic ref_clk_i, sys_rst_i, rxd_i, chan_set_i, txd_o, aux_txd_o, video_on_o, frame_err_o;
	logic [4:0] chan_set_val_i, chan_o, v;
	logic [7:0] echo, bad, aux;
	int err_total = 0;
	int checked = 0;
	int ferr_n = 0;
	pss_serial_port_select u_pss_serial_port_select (.*);
	pss_host u_pss_host (.clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
	pss_host u_pss_host_aux (.clk_i(ref_clk_i), .txd_i(aux_txd_o), .rxd_o());
	always @(posedge ref_clk_i) if (frame_err_o) ferr_n <= ferr_n + 1;
	function automatic logic [7:0] want(input logic [7:0] b);
		return (b == 8'h71) ? 8'h0 : b - 8'hf;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#2000000;
		err_total++;
		summarize();
	end
	initial begin
		sys_rst_i = 1'b1;
		chan_set_i = 1'b0;
		chan_set_val_i = 5'h0;
		void'($urandom(32'hb2771a8b));
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		// Top code then a junk byte back to back
		bad = 8'h20 + 8'($urandom_range(80));
		fork
			begin
				u_pss_host.send(8'h1f);
				u_pss_host.send(bad);
			end
			u_pss_host.recv(echo);
			u_pss_host_aux.recv(aux);
		join
		chk("echo", 8'h1f, echo);
		chk("aux", 8'h1f, aux);
		chk("frame err", 8'h0, 8'(ferr_n));
		chk("chan", want(8'h1f), 8'(chan_o));
		chk("no echo", 8'h1, 8'(txd_o));
		$display("serial test done");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 5'h0 : 5'($urandom_range(16));
			chan_set_i <= 1'b1;
			chan_set_val_i <= v;
			@(posedge ref_clk_i);
			chan_set_i <= 1'b0;
			repeat (2) @(posedge ref_clk_i);
			chk("local", 8'(v), 8'(chan_o));
			chk("video", 8'(v != 5'h0), 8'(video_on_o));
		end
		$display("local test done");
		summarize();
	end
endmodule
bind pss_serial_port_select pss_props u_pss_props (.*);
